/* hw/assr_top.sv */
// Purpose: alu status and bank select register with apb access
// Assumes: apb master holds each request until pready; pclk 100 MHz
// Notes:   a write to the core register runs one instruction against the status register
//
// How it works
// - one status byte holds alu flags, reset-cause flags and bank select bits.
// - any instruction may name the status register as destination like a file register.
// - a flag-updating instruction aimed at the status register loses its write to zero, nibble carry and carry.
// - data writes never change the expiry and sleep-entry flags; only the kick, sleep and expire ops do.
// - clearing the status register zeroes the top three bits, keeps bits 4..0 except the zero flag, which is set.
// - subtraction gives carry as inverted borrow and nibble carry as inverted nibble borrow.
// - bit 7 picks banks 2-3 for indirect addressing when one, banks 0-1 when zero.
// - bits 6-5 pick one of four 128-byte direct banks.
`timescale 1ns/1ps
module assr_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  direct_addr,
   input  wire logic [7:0]  indirect_ptr,
   output logic      [7:0]  status_out,
   output logic      [7:0]  result_out,
   output logic      [8:0]  direct_full_addr,
   output logic      [8:0]  indirect_full_addr
);
   import assr_pkg::*;

   typedef struct packed {
      assr_state_e state;
      logic [7:0]  status;
      logic [7:0]  result;
      logic [23:0] core;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic [8:0]  dfull;
      logic [8:0]  ifull;
   } assr_regs_s;

   assr_regs_s r_reg;
   assr_regs_s r_next;

   assr_alu_if alu_bus ();
   logic [8:0] dfull_w;
   logic [8:0] ifull_w;

   assr_alu u_alu (
      .a (alu_bus.alu)
   );

   assr_bank_decode u_bank (
      .status        (r_reg.status),
      .direct_addr   (direct_addr),
      .indirect_ptr  (indirect_ptr),
      .direct_full   (dfull_w),
      .indirect_full (ifull_w)
   );

   logic       setup;
   logic       access;
   logic [3:0] wr_op;
   logic       wr_dst;
   logic [2:0] wr_idx;
   logic [7:0] wr_w;
   logic [7:0] wr_f;
   logic [7:0] operand_f;

   assign setup  = psel && !penable;
   assign access = psel && penable && (r_reg.state == ASSR_ST_ACCESS);
   assign wr_op  = pwdata[ASSR_CORE_OP_LSB +: 4];
   assign wr_dst = pwdata[ASSR_CORE_DST_BIT];
   assign wr_idx = pwdata[ASSR_CORE_IDX_LSB +: 3];
   assign wr_w   = pwdata[ASSR_CORE_W_LSB +: 8];
   assign wr_f   = pwdata[ASSR_CORE_F_LSB +: 8];
   // when the destination is status the status byte itself is the file operand
   assign operand_f = wr_dst ? r_reg.status : wr_f;

   assign alu_bus.op    = wr_op;
   assign alu_bus.w_val = wr_w;
   assign alu_bus.f_val = operand_f;

   // status image after an instruction runs
   function automatic logic [7:0] exec_status(
      input logic [7:0] st,
      input logic [3:0] op,
      input logic       dst,
      input logic [2:0] idx,
      input logic [7:0] res,
      input logic       z,
      input logic       dc,
      input logic       c,
      input logic       fv,
      input logic [7:0] wv
   );
      logic [7:0] n;
      logic [7:0] dat;
      n   = st;
      dat = res;
      case (op)
         ASSR_OP_BITCLR: dat = st & ~(8'h01 << idx);
         ASSR_OP_BITSET: dat = st | (8'h01 << idx);
         ASSR_OP_SWAP:   dat = {st[3:0], st[7:4]};
         ASSR_OP_MOVE:   dat = wv;
         ASSR_OP_ZERO:   dat = 8'h00;
         default:        dat = res;
      endcase
      // data write to status, protected flags kept
      if (dst && op != ASSR_OP_NONE && op != ASSR_OP_KICK && op != ASSR_OP_SLEEP && op != ASSR_OP_EXPIRE) begin
         n = (st & ~ASSR_WRITE_MASK) | (dat & ASSR_WRITE_MASK);
      end
      if (op == ASSR_OP_ZERO) begin
         n = st & ASSR_CLEAR_KEEP;
         n[ASSR_BIT_ZERO] = 1'b1;
      end
      if (op == ASSR_OP_LOGIC) begin
         // and only updates zero, but the data write to nibble carry and carry is blocked as well
         n[ASSR_BIT_ZERO]   = z;
         n[ASSR_BIT_NIBBLE] = st[ASSR_BIT_NIBBLE];
         n[ASSR_BIT_CARRY]  = st[ASSR_BIT_CARRY];
      end
      if (fv) begin
         n[ASSR_BIT_ZERO]   = z;
         n[ASSR_BIT_NIBBLE] = dc;
         n[ASSR_BIT_CARRY]  = c;
      end
      case (op)
         ASSR_OP_KICK: begin
            n[ASSR_BIT_EXPIRY] = 1'b1;
            n[ASSR_BIT_SLEEP]  = 1'b1;
         end
         ASSR_OP_SLEEP: begin
            n[ASSR_BIT_EXPIRY] = 1'b1;
            n[ASSR_BIT_SLEEP]  = 1'b0;
         end
         ASSR_OP_EXPIRE: begin
            n[ASSR_BIT_EXPIRY] = 1'b0;
         end
         default: begin
         end
      endcase
      return n;
   endfunction : exec_status

   always_comb begin
      r_next        = r_reg;
      r_next.ready  = 1'b0;
      r_next.slverr = 1'b0;
      r_next.dfull  = dfull_w;
      r_next.ifull  = ifull_w;
      case (r_reg.state)
         ASSR_ST_IDLE: begin
            if (setup) begin
               r_next.state = ASSR_ST_ACCESS;
            end
         end
         ASSR_ST_ACCESS: begin
            if (access && !r_reg.ready) begin
               r_next.ready = 1'b1;
               if (pwrite) begin
                  if (paddr == ASSR_STATUS_OFFSET) begin
                     // direct store to status: a plain move through the protect mask
                     r_next.status = (r_reg.status & ~ASSR_WRITE_MASK)
                                   | (pwdata[7:0] & ASSR_WRITE_MASK);
                  end else if (paddr == ASSR_CORE_OFFSET) begin
                     r_next.core   = pwdata[23:0];
                     r_next.result = alu_bus.result;
                     r_next.status = exec_status(r_reg.status, wr_op, wr_dst, wr_idx,
                                                 alu_bus.result, alu_bus.zero,
                                                 alu_bus.nibble_carry, alu_bus.carry,
                                                 alu_bus.flags_valid, wr_w);
                  end else if (paddr == ASSR_BANK_OFFSET) begin
                     r_next.slverr = 1'b0;
                  end else begin
                     r_next.slverr = 1'b1;
                  end
               end else begin
                  if (paddr == ASSR_STATUS_OFFSET) begin
                     r_next.rdata = {24'h000000, r_reg.status};
                  end else if (paddr == ASSR_CORE_OFFSET) begin
                     r_next.rdata = {r_reg.result, r_reg.core};
                  end else if (paddr == ASSR_BANK_OFFSET) begin
                     r_next.rdata = {7'h00, r_reg.ifull, 7'h00, r_reg.dfull};
                  end else begin
                     r_next.rdata  = 32'h00000000;
                     r_next.slverr = 1'b1;
                  end
               end
            end else if (r_reg.ready) begin
               r_next.state = setup ? ASSR_ST_ACCESS : ASSR_ST_IDLE;
            end
         end
         default: begin
            r_next.state = ASSR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg.state  <= ASSR_ST_IDLE;
         r_reg.status <= ASSR_STATUS_RESET;
         r_reg.result <= 8'h00;
         r_reg.core   <= 24'h000000;
         r_reg.rdata  <= 32'h00000000;
         r_reg.ready  <= 1'b0;
         r_reg.slverr <= 1'b0;
         r_reg.dfull  <= 9'h000;
         r_reg.ifull  <= 9'h000;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata             = r_reg.rdata;
   assign pready             = r_reg.ready;
   assign pslverr            = r_reg.slverr;
   assign status_out         = r_reg.status;
   assign result_out         = r_reg.result;
   assign direct_full_addr   = r_reg.dfull;
   assign indirect_full_addr = r_reg.ifull;

endmodule : assr_top

/* hw/assr_pkg.sv */
// Purpose: constants and types for the alu status and bank select register block
// Assumes: 32-bit apb, one aligned word per register
// Notes:   bit positions of the status byte and the apb map live here
package assr_pkg;

   localparam logic [7:0] ASSR_STATUS_OFFSET = 8'h00;
   localparam logic [7:0] ASSR_CORE_OFFSET   = 8'h04;
   localparam logic [7:0] ASSR_BANK_OFFSET   = 8'h08;

   localparam int ASSR_BIT_CARRY  = 0;
   localparam int ASSR_BIT_NIBBLE = 1;
   localparam int ASSR_BIT_ZERO   = 2;
   localparam int ASSR_BIT_SLEEP  = 3;
   localparam int ASSR_BIT_EXPIRY = 4;
   localparam int ASSR_BIT_RP0    = 5;
   localparam int ASSR_BIT_RP1    = 6;
   localparam int ASSR_BIT_IRP    = 7;

   // reset value: banks 0, both reset-cause flags one, alu flags zero
   localparam logic [7:0] ASSR_STATUS_RESET = 8'h18;
   // mask of bits that an ordinary write may change
   localparam logic [7:0] ASSR_WRITE_MASK   = 8'he7;
   localparam logic [7:0] ASSR_ALU_MASK     = 8'h07;
   localparam logic [7:0] ASSR_CLEAR_KEEP   = 8'h1b;

   localparam logic [8:0] ASSR_BANK_SIZE    = 9'h080;

   // core operation codes written to the core register
   typedef enum logic [3:0] {
      ASSR_OP_NONE     = 4'b0000,
      ASSR_OP_ADD      = 4'b0001,
      ASSR_OP_SUB      = 4'b0010,
      ASSR_OP_LOGIC    = 4'b0011,
      ASSR_OP_MOVE     = 4'b0100,
      ASSR_OP_ZERO     = 4'b0101,
      ASSR_OP_KICK     = 4'b0110,
      ASSR_OP_SLEEP    = 4'b0111,
      ASSR_OP_EXPIRE   = 4'b1000,
      ASSR_OP_BITCLR   = 4'b1001,
      ASSR_OP_BITSET   = 4'b1010,
      ASSR_OP_SWAP     = 4'b1011
   } assr_op_e;

   // core register fields: [3:0] op, [4] target is status, [7:5] bit index, [15:8] w, [23:16] f
   localparam int ASSR_CORE_OP_LSB   = 0;
   localparam int ASSR_CORE_DST_BIT  = 4;
   localparam int ASSR_CORE_IDX_LSB  = 5;
   localparam int ASSR_CORE_W_LSB    = 8;
   localparam int ASSR_CORE_F_LSB    = 16;

   typedef enum logic [1:0] {
      ASSR_ST_IDLE   = 2'b00,
      ASSR_ST_ACCESS = 2'b01
   } assr_state_e;

endpackage : assr_pkg

/* hw/assr_alu_if.sv */
// Purpose: carries one core operation and its flag result between modules
// Assumes: single clock domain
// Notes:   the core drives the request, the alu drives the result
`timescale 1ns/1ps
interface assr_alu_if;
   logic [3:0] op;
   logic [7:0] w_val;
   logic [7:0] f_val;
   logic [7:0] result;
   logic       zero;
   logic       nibble_carry;
   logic       carry;
   logic       flags_valid;

   modport core (output op, output w_val, output f_val,
                 input result, input zero, input nibble_carry, input carry, input flags_valid);
   modport alu  (input op, input w_val, input f_val,
                 output result, output zero, output nibble_carry, output carry, output flags_valid);
endinterface : assr_alu_if

/* hw/assr_alu.sv */
// Purpose: combinational alu producing the result and its three status flags
// Assumes: operands valid for the whole cycle
// Notes:   flags_valid marks operations that update zero, nibble carry and carry
`timescale 1ns/1ps
module assr_alu (
   assr_alu_if.alu a
);
   import assr_pkg::*;

   logic [8:0] sum;
   logic [4:0] low_sum;

   always_comb begin
      sum           = 9'h000;
      low_sum       = 5'h00;
      a.result      = 8'h00;
      a.zero        = 1'b0;
      a.nibble_carry = 1'b0;
      a.carry       = 1'b0;
      a.flags_valid = 1'b0;
      case (a.op)
         ASSR_OP_ADD: begin
            sum           = {1'b0, a.f_val} + {1'b0, a.w_val};
            low_sum       = {1'b0, a.f_val[3:0]} + {1'b0, a.w_val[3:0]};
            a.result      = sum[7:0];
            a.carry       = sum[8];
            a.nibble_carry = low_sum[4];
            a.zero        = (sum[7:0] == 8'h00);
            a.flags_valid = 1'b1;
         end
         ASSR_OP_SUB: begin
            // f minus w as f plus two's complement of w: carry out is not-borrow
            sum           = {1'b0, a.f_val} + {1'b0, ~a.w_val} + 9'h001;
            low_sum       = {1'b0, a.f_val[3:0]} + {1'b0, ~a.w_val[3:0]} + 5'h01;
            a.result      = sum[7:0];
            a.carry       = sum[8];
            a.nibble_carry = low_sum[4];
            a.zero        = (sum[7:0] == 8'h00);
            a.flags_valid = 1'b1;
         end
         ASSR_OP_LOGIC: begin
            a.result = a.f_val & a.w_val;
            a.zero   = (a.result == 8'h00);
         end
         default: begin
            a.result = a.w_val;
         end
      endcase
   end

endmodule : assr_alu

/* hw/assr_bank_decode.sv */
// Purpose: turns the bank select bits and an address into a data memory address
// Assumes: 7-bit direct address, 8-bit indirect pointer
// Notes:   purely combinational
`timescale 1ns/1ps
module assr_bank_decode (
   input  wire logic [7:0] status,
   input  wire logic [6:0] direct_addr,
   input  wire logic [7:0] indirect_ptr,
   output logic      [8:0] direct_full,
   output logic      [8:0] indirect_full
);
   import assr_pkg::*;

   // each bank is 128 bytes, so the two select bits form address bits 8:7
   assign direct_full   = {status[ASSR_BIT_RP1], status[ASSR_BIT_RP0], direct_addr};
   // the indirect pair bit lifts the pointer into banks 2 and 3
   assign indirect_full = {status[ASSR_BIT_IRP], indirect_ptr};

endmodule : assr_bank_decode

/* test/assr_top_chk.sv */
// Purpose: port-level assertions for the status and bank select register
// Assumes: one wait state per apb access, ops reach status on the same edge that raises pready
// Notes:   bound to assr_top below
`timescale 1ns/1ps
module assr_top_chk
   import assr_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [6:0]  direct_addr,
   input wire logic [7:0]  indirect_ptr,
   input wire logic [7:0]  status_out,
   input wire logic [7:0]  result_out,
   input wire logic [8:0]  direct_full_addr,
   input wire logic [8:0]  indirect_full_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   function automatic logic [2:0] add_f(logic [7:0] w, logic [7:0] f);
      logic [8:0] s;
      s = {1'b0, w} + {1'b0, f};
      return {s[7:0] == 8'h00, ({1'b0, w[3:0]} + {1'b0, f[3:0]}) > 5'h0f, s[8]};
   endfunction : add_f

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_core(logic [3:0] op, logic d);
      psel && penable && pready && pwrite && paddr == ASSR_CORE_OFFSET && pwdata[3:0] == op && pwdata[4] == d;
   endsequence
   sequence s_stat_wr;
      psel && penable && pready && pwrite && paddr == ASSR_STATUS_OFFSET;
   endsequence

   a_ready_wait: assert property (s_setup |=> !pready ##1 pready ##1 !pready)
      else $error("pready not after one wait state");
   a_status_write: assert property (s_stat_wr |=> status_out[7:5] == $past(pwdata[7:5])
      && status_out[2:0] == $past(pwdata[2:0]) && status_out[4:3] == $past(status_out[4:3], 2))
      else $error("status write mask wrong");
   a_clear_keep: assert property (s_core(4'h5, 1'b1) |=> status_out ==
      {3'b000, $past(status_out[4:3], 2), 1'b1, $past(status_out[1:0], 2)}) else $error("clear result wrong");
   a_kick_flags: assert property (s_core(4'h6, 1'b0) |=> status_out[4:3] == 2'b11)
      else $error("kick flags wrong");
   a_sleep_flags: assert property (s_core(4'h7, 1'b0) |=> status_out[4:3] == 2'b10)
      else $error("sleep flags wrong");
   a_expiry_clear: assert property (s_core(4'h8, 1'b0) |=> !status_out[4]
      && status_out[3] == $past(status_out[3], 2)) else $error("expiry flags wrong");
   a_add_flags: assert property (s_core(4'h1, 1'b0) |=> status_out[2:0] == add_f($past(pwdata[15:8]),
      $past(pwdata[23:16])) && result_out == $past(pwdata[15:8]) + $past(pwdata[23:16]))
      else $error("add flags wrong");
   a_sub_flags: assert property (s_core(4'h2, 1'b0) |=> status_out[2:0] ==
      {$past(pwdata[23:16]) == $past(pwdata[15:8]), $past(pwdata[19:16]) >= $past(pwdata[11:8]),
      $past(pwdata[23:16]) >= $past(pwdata[15:8])})
      else $error("sub flags wrong");
   a_logic_keep: assert property (s_core(4'h3, 1'b1) |=> status_out[1:0] == $past(status_out[1:0], 2))
      else $error("and op wrote nibble carry or carry");
   a_bank_direct: assert property (direct_full_addr == $past({status_out[6:5], direct_addr}))
      else $error("direct bank address wrong");
   a_bank_indirect: assert property (indirect_full_addr == $past({status_out[7], indirect_ptr}))
      else $error("indirect bank address wrong");
   a_err_unmapped: assert property (pready && !pwrite && paddr == 8'h0c |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
endmodule : assr_top_chk

bind assr_top assr_top_chk assr_top_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .direct_addr, .indirect_ptr, .status_out, .result_out, .direct_full_addr, .indirect_full_addr);

/* test/assr_top_tb_top.sv */
// Purpose: apb directed tests of the status and bank select register
// Assumes: pclk 100 MHz, one wait state per access
// Notes:   core ops run from a table of command words and expected status
`timescale 1ns/1ps
module assr_top_tb_top;
   import assr_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, indirect_ptr, status_out, result_out;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  direct_addr;
   logic [8:0]  direct_full_addr, indirect_full_addr;
   logic [31:0] cw [17];
   logic [7:0]  es [17];
   int          mismatches, n_tests;

   assr_top assr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .direct_addr, .indirect_ptr, .status_out, .result_out, .direct_full_addr, .indirect_full_addr);

   always #5 pclk = ~pclk;

   task automatic final_report();
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         mismatches++;
         final_report();
      end
   endtask : apb

   task automatic chk_st(input logic [7:0] e);
      apb(1'b0, ASSR_STATUS_OFFSET, 32'h0, rd, er);
      chk("status_read", {24'h0, e}, {24'h0, rd[7:0]});
      chk("status_out", {24'h0, e}, {24'h0, status_out});
   endtask : chk_st

   initial begin
      #50000;
      mismatches++;
      final_report();
   end

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      direct_addr = 0; indirect_ptr = 0; mismatches = 0; n_tests = 0;
      cw = '{32'h08, 32'hff14, 32'h15, 32'h06, 32'h07, 32'h10f01, 32'h808001, 32'h50302, 32'h30502, 32'hff11,
             32'hba, 32'h19, 32'h1b, 32'hf00f03, 32'h00, 32'he413, 32'he014};
      es = '{8'hef, 8'hef, 8'h0f, 8'h1f, 8'h17, 8'h12, 8'h15, 8'h13, 8'h10, 8'h11, 8'h31, 8'h30, 8'h13, 8'h17,
             8'h17, 8'h13, 8'hf0};
      repeat (11) @(posedge pclk);
      #1;
      chk("reset_status", 32'h18, {24'h0, status_out});
      chk("reset_ready", 32'h0, {31'h0, pready});
      @(posedge pclk);
      presetn <= 1'b1;
      chk_st(8'h18);
      apb(1'b1, ASSR_STATUS_OFFSET, 32'h0, rd, er);
      chk_st(8'h18);
      apb(1'b1, ASSR_STATUS_OFFSET, 32'hff, rd, er);
      chk_st(8'hff);
      for (int i = 0; i < 17; i++) begin
         apb(1'b1, ASSR_CORE_OFFSET, cw[i], rd, er);
         chk_st(es[i]);
      end
      apb(1'b0, ASSR_CORE_OFFSET, 32'h0, rd, er);
      chk("core_readback", 32'he000e014, rd);
      chk("result_out", 32'he0, {24'h0, result_out});
      direct_addr <= 7'h55;
      indirect_ptr <= 8'haa;
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, ASSR_STATUS_OFFSET, 32'(k << 5), rd, er);
         apb(1'b0, ASSR_BANK_OFFSET, 32'h0, rd, er);
         chk("direct_full", {23'h0, k[1:0], 7'h55}, {23'h0, direct_full_addr});
         chk("indirect_full", {23'h0, k[2], 8'haa}, {23'h0, indirect_full_addr});
         chk("bank_readback", {7'h0, k[2], 8'haa, 7'h0, k[1:0], 7'h55}, {7'h0, rd[24:16], 7'h0, rd[8:0]});
      end
      apb(1'b1, 8'h0c, 32'hff, rd, er);
      chk("unmapped_wr_err", 32'h1, {31'h0, er});
      apb(1'b0, 8'h0c, 32'h0, rd, er);
      chk("unmapped_rd_err", 32'h1, {31'h0, er});
      chk("unmapped_rd_data", 32'h0, rd);
      chk_st(8'hf0);
      // return the bank select bits to zero
      apb(1'b1, ASSR_STATUS_OFFSET, 32'h0, rd, er);
      chk("mapped_err", 32'h0, {31'h0, er});
      chk_st(8'h10);
      final_report();
   end
endmodule : assr_top_tb_top
